// ===== hw/wdcs_consts.svh
// Register map, field positions, reset values and timing counts.
`ifndef WDCS_CONSTS_SVH
`define WDCS_CONSTS_SVH

// ==========================================================================
// Register offsets on the special function register bus
`define WDCS_ADDR_BOOT_SEL   8'hD7
`define WDCS_ADDR_CTRL       8'hD8

// ==========================================================================
// Field positions
`define WDCS_BIT_BOOT_LOADER 0
`define WDCS_BIT_POR         6
`define WDCS_BIT_TIMEOUT_IRQ 3
`define WDCS_BIT_WD_RESET    2
`define WDCS_BIT_RESET_EN    1
`define WDCS_BIT_RESTART     0

// ==========================================================================
// Reset values and constants
`define WDCS_POR_FLAG_RESET  1'b1
`define WDCS_RESTART_ADDR    16'h0000
`define WDCS_RST_DELAY_CLKS  512

`endif

// ===== hw/wdcs_pkg.sv
// Types shared by the watchdog control and status block.
package wdcs_pkg;

	// ======================================================================
	// Delayed reset sequencer states
	typedef enum logic [0:0] {
		WDCS_DLY_IDLE = 1'b0,
		WDCS_DLY_WAIT = 1'b1
	} wdcs_dly_state_t;

	// Restart area selector
	typedef enum logic [0:0] {
		WDCS_AREA_APP    = 1'b0,
		WDCS_AREA_LOADER = 1'b1
	} wdcs_area_t;

endpackage : wdcs_pkg

// ===== hw/wdcs_reset_delay.sv
// Delay sequencer that fires a system reset a fixed count after time-out.
`timescale 1ns/1ps
`include "wdcs_consts.svh"

module wdcs_reset_delay #(
	parameter int DELAY_CLKS = `WDCS_RST_DELAY_CLKS
) (
	// Clock and reset
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	// Control
	input  wire logic start_in,
	input  wire logic cancel_in,
	// Result
	output logic      fire_out
);
	import wdcs_pkg::*;

	localparam int CW = $clog2(DELAY_CLKS) + 1;
	localparam logic [CW-1:0] LAST = CW'(DELAY_CLKS - 1);

	initial begin
		if (DELAY_CLKS < 2) begin
			$error("DELAY_CLKS must be at least 2");
		end
	end

	wdcs_dly_state_t state_q;
	wdcs_dly_state_t state_d;
	logic [CW-1:0]   cnt_q;
	logic [CW-1:0]   cnt_d;
	logic            fire_d;

	// ======================================================================
	// Next state
	wire at_last = (state_q == WDCS_DLY_WAIT) && (cnt_q == LAST);

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		fire_d  = 1'b0;
		case (state_q)
			WDCS_DLY_IDLE: begin
				cnt_d = '0;
				if (start_in && !cancel_in) begin
					state_d = WDCS_DLY_WAIT;
				end
			end
			WDCS_DLY_WAIT: begin
				if (cancel_in) begin
					state_d = WDCS_DLY_IDLE;
					cnt_d   = '0;
				end else if (at_last) begin
					state_d = WDCS_DLY_IDLE;
					cnt_d   = '0;
					fire_d  = 1'b1;
				end else begin
					cnt_d = cnt_q + CW'(1);
				end
			end
			default: begin
				state_d = WDCS_DLY_IDLE;
			end
		endcase
	end

	// ======================================================================
	// Registers
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q  <= WDCS_DLY_IDLE;
			cnt_q    <= '0;
			fire_out <= 1'b0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			fire_out <= fire_d;
		end
	end

endmodule : wdcs_reset_delay

// ===== hw/wdcs_top.sv
// Watchdog control and status registers with delayed reset and boot select.
`timescale 1ns/1ps
`include "wdcs_consts.svh"

module wdcs_top #(
	parameter int RESET_DELAY_CLKS = `WDCS_RST_DELAY_CLKS
) (
	// Clock and power-on reset
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	// Other reset sources, one-cycle pulses from the reset controller
	input  wire logic        ext_reset_in,
	input  wire logic        isp_reset_in,
	// Special function register bus
	input  wire logic [7:0]  sfr_addr_in,
	input  wire logic        sfr_wr_in,
	input  wire logic        sfr_rd_in,
	input  wire logic [7:0]  sfr_wdata_in,
	output logic      [7:0]  sfr_rdata_out,
	// Watchdog counter and interrupt controller side
	input  wire logic        timeout_in,
	input  wire logic        timeout_irq_enable_in,
	input  wire logic        timed_access_unlock_in,
	output logic             counter_clear_out,
	output logic             wd_irq_out,
	// Restart control
	output logic             sys_reset_out,
	output wdcs_pkg::wdcs_area_t boot_from_loader_out,
	output logic      [15:0] restart_addr_out
);
	import wdcs_pkg::*;

	initial begin
		if (RESET_DELAY_CLKS < 2) begin
			$error("RESET_DELAY_CLKS must be at least 2");
		end
	end

	// ======================================================================
	// State
	logic        boot_loader_q;
	logic        boot_loader_d;
	logic        por_flag_q;
	logic        por_flag_d;
	logic        timeout_irq_flag_q;
	logic        timeout_irq_flag_d;
	logic        wd_reset_flag_q;
	logic        wd_reset_flag_d;
	logic        wd_reset_enable_q;
	logic        wd_reset_enable_d;
	logic        wd_counter_restart_q;
	logic        wd_counter_restart_d;
	logic        irq_d;
	logic [7:0]  rdata_d;
	wdcs_area_t  area_d;
	logic        wd_fire;

	// ======================================================================
	// Address decode and write qualification
	wire hit_boot = (sfr_addr_in == `WDCS_ADDR_BOOT_SEL);
	wire hit_ctrl = (sfr_addr_in == `WDCS_ADDR_CTRL);

	wire wr_boot_prot = sfr_wr_in && hit_boot && timed_access_unlock_in;
	wire wr_ctrl_free = sfr_wr_in && hit_ctrl;
	// Writes to protected control bits only take effect while unlock is present.
	wire wr_ctrl_prot = wr_ctrl_free && timed_access_unlock_in;

	// External pin or ISP reset, seen as a synchronous pulse; the watchdog reset is not included.
	wire pin_or_isp   = ext_reset_in || isp_reset_in;

	// Reserved bits read as zero.
	wire [7:0] ctrl_view = {1'b0, por_flag_q, 2'b00, timeout_irq_flag_q,
		wd_reset_flag_q, wd_reset_enable_q, wd_counter_restart_q};
	wire [7:0] boot_view = {7'h00, boot_loader_q};

	// ======================================================================
	// Next values of the register bits
	always_comb begin
		boot_loader_d = boot_loader_q;
		if (wr_boot_prot) begin
			boot_loader_d = sfr_wdata_in[`WDCS_BIT_BOOT_LOADER];
		end
	end

	// Power-up sets it through the asynchronous reset; only writes clear it.
	always_comb begin
		por_flag_d = por_flag_q;
		if (wr_ctrl_prot) begin
			por_flag_d = sfr_wdata_in[`WDCS_BIT_POR];
		end
	end

	// A time-out in the same cycle as a clearing write wins.
	always_comb begin
		timeout_irq_flag_d = timeout_irq_flag_q;
		if (timeout_in) begin
			timeout_irq_flag_d = 1'b1;
		end else if (ext_reset_in) begin
			timeout_irq_flag_d = 1'b0;
		end else if (wr_ctrl_prot) begin
			timeout_irq_flag_d = sfr_wdata_in[`WDCS_BIT_TIMEOUT_IRQ];
		end
	end

	// This flag is writable without unlock.
	always_comb begin
		wd_reset_flag_d = wd_reset_flag_q;
		if (wd_fire) begin
			wd_reset_flag_d = 1'b1;
		end else if (ext_reset_in) begin
			wd_reset_flag_d = 1'b0;
		end else if (wr_ctrl_free) begin
			wd_reset_flag_d = sfr_wdata_in[`WDCS_BIT_WD_RESET];
		end
	end

	always_comb begin
		wd_reset_enable_d = wd_reset_enable_q;
		if (pin_or_isp || wd_fire) begin
			wd_reset_enable_d = 1'b0;
		end else if (wr_ctrl_prot) begin
			wd_reset_enable_d = sfr_wdata_in[`WDCS_BIT_RESET_EN];
		end
	end

	// The restart bit lives for one cycle and then clears itself.
	always_comb begin
		wd_counter_restart_d = 1'b0;
		if (wr_ctrl_prot && !pin_or_isp) begin
			wd_counter_restart_d = sfr_wdata_in[`WDCS_BIT_RESTART];
		end
	end

	// Interrupt request follows the flag of the next cycle and the enable of this one.
	assign irq_d = timeout_irq_flag_d && timeout_irq_enable_in;

	// Registered read data; zero when no read is made.
	assign rdata_d = !sfr_rd_in ? 8'h00 :
		hit_ctrl ? ctrl_view :
		hit_boot ? boot_view : 8'h00;

	// Restart area: watchdog reset follows boot select, others use the
	// application area.
	assign area_d = wd_fire ? wdcs_area_t'(boot_loader_q) :
		pin_or_isp ? WDCS_AREA_APP : boot_from_loader_out;

	// ======================================================================
	// Delayed system reset after time-out
	// A restart, a cleared enable or another reset abandons a pending reset,
	// so software that services the dog in time still escapes it.
	wire dly_start  = timeout_in && wd_reset_enable_q;
	wire dly_cancel = wd_counter_restart_q || !wd_reset_enable_q ||
		pin_or_isp;

	wdcs_reset_delay #(
		.DELAY_CLKS (RESET_DELAY_CLKS)
	) u_delay (
		.clock_in  (clock_in),
		.rst_n_in  (rst_n_in),
		.start_in  (dly_start),
		.cancel_in (dly_cancel),
		.fire_out  (wd_fire)
	);

	// ======================================================================
	// Registers
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			boot_loader_q        <= 1'b0;
			por_flag_q           <= `WDCS_POR_FLAG_RESET;
			timeout_irq_flag_q   <= 1'b0;
			wd_reset_flag_q      <= 1'b0;
			wd_reset_enable_q    <= 1'b0;
			wd_counter_restart_q <= 1'b0;
		end else begin
			boot_loader_q        <= boot_loader_d;
			por_flag_q           <= por_flag_d;
			timeout_irq_flag_q   <= timeout_irq_flag_d;
			wd_reset_flag_q      <= wd_reset_flag_d;
			wd_reset_enable_q    <= wd_reset_enable_d;
			wd_counter_restart_q <= wd_counter_restart_d;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sfr_rdata_out        <= 8'h00;
			wd_irq_out           <= 1'b0;
			boot_from_loader_out <= WDCS_AREA_APP;
			restart_addr_out     <= `WDCS_RESTART_ADDR;
		end else begin
			sfr_rdata_out        <= rdata_d;
			wd_irq_out           <= irq_d;
			boot_from_loader_out <= area_d;
			restart_addr_out     <= `WDCS_RESTART_ADDR;
		end
	end

	// Counter clear and system reset are copies of flip-flops.
	assign counter_clear_out = wd_counter_restart_q;
	assign sys_reset_out     = wd_fire;

endmodule : wdcs_top

// ===== verification/wdcs_cpu_model.sv
// CPU core model that drives the special function register bus.
`timescale 1ns/1ps
module wdcs_cpu_model (
	// Clock
	input  wire logic       clock_in,
	// Register bus towards the block
	output logic      [7:0] sfr_addr_out,
	output logic            sfr_wr_out,
	output logic            sfr_rd_out,
	output logic      [7:0] sfr_wdata_out,
	output logic            unlock_out,
	input  wire logic [7:0] sfr_rdata_in
);
	initial begin
		sfr_addr_out = 8'h00;
		sfr_wdata_out = 8'h00;
		{sfr_wr_out, sfr_rd_out, unlock_out} = 3'b000;
	end
	// ==========
	// Unlock is held only with the write it grants, so no stale grant
	// can leak into a later access. After a write, address and data show the inverse value; a read inverts only the address.
	task automatic write_reg(input logic [7:0] a, d, input logic u);
		@(posedge clock_in);
		#1;
		sfr_addr_out = a;
		sfr_wdata_out = d;
		unlock_out = u;
		sfr_wr_out = 1'b1;
		@(posedge clock_in);
		#1;
		{sfr_wr_out, unlock_out} = 2'b00;
		sfr_addr_out = ~a;
		sfr_wdata_out = ~d;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_in);
		#1;
		sfr_addr_out = a;
		sfr_rd_out = 1'b1;
		@(posedge clock_in);
		#1;
		d = sfr_rdata_in;
		sfr_rd_out = 1'b0;
		sfr_addr_out = ~a;
	endtask : read_reg
endmodule : wdcs_cpu_model

// ===== verification/wdcs_top_assertions.sv
// Concurrent checks on the watchdog control and status ports.
`timescale 1ns/1ps
`include "wdcs_consts.svh"
module wdcs_top_assertions #(
	parameter int RESET_DELAY_CLKS = 512
) (
	// Clock, resets and register bus
	input wire logic       clock_in,
	input wire logic       rst_n_in,
	input wire logic       ext_reset_in,
	input wire logic       isp_reset_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic       sfr_wr_in,
	input wire logic       sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	// Watchdog side and restart control
	input wire logic       timeout_in,
	input wire logic       timeout_irq_enable_in,
	input wire logic       timed_access_unlock_in,
	input wire logic       counter_clear_out,
	input wire logic       wd_irq_out,
	input wire logic       sys_reset_out,
	input wire wdcs_pkg::wdcs_area_t boot_from_loader_out,
	input wire logic [15:0] restart_addr_out
);
	import wdcs_pkg::*;
	// ==========
	// A restart write is refused while a reset pulse is present.
	wire clr_req = sfr_wr_in && sfr_addr_in == `WDCS_ADDR_CTRL &&
		sfr_wdata_in[0] && timed_access_unlock_in &&
		!ext_reset_in && !isp_reset_in;
	wire rd_map = sfr_addr_in == `WDCS_ADDR_CTRL ||
		sfr_addr_in == `WDCS_ADDR_BOOT_SEL;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	property p_clr_set; clr_req |=> counter_clear_out; endproperty
	property p_clr_why; counter_clear_out |-> $past(clr_req); endproperty
	property p_rd_idle; !$past(sfr_rd_in) |-> sfr_rdata_out == 8'h00;
	endproperty
	property p_rd_unmap; $past(sfr_rd_in) && !$past(rd_map)
		|-> sfr_rdata_out == 8'h00; endproperty
	property p_rd_rsvd; $past(sfr_rd_in) && $past(sfr_addr_in) == 8'hD8
		|-> (sfr_rdata_out & 8'hB0) == 8'h00; endproperty
	property p_irq_set; timeout_in && timeout_irq_enable_in &&
		!ext_reset_in |=> wd_irq_out; endproperty
	property p_irq_gate; wd_irq_out |-> $past(timeout_irq_enable_in);
	endproperty
	property p_sys_pulse; sys_reset_out |=> !sys_reset_out; endproperty
	property p_sys_delay;
		sys_reset_out |-> $past(timeout_in, RESET_DELAY_CLKS + 1);
	endproperty
	property p_boot; !$stable(boot_from_loader_out) |->
		$past(sys_reset_out || ext_reset_in || isp_reset_in); endproperty
	property p_addr; restart_addr_out == 16'h0000; endproperty
	a_clr_set: assert property (p_clr_set) else $error("no clear");
	a_clr_why: assert property (p_clr_why) else $error("clear");
	a_rd_idle: assert property (p_rd_idle) else $error("rd idle");
	a_rd_unmap: assert property (p_rd_unmap) else $error("unmap");
	a_rd_rsvd: assert property (p_rd_rsvd) else $error("rsvd");
	a_irq_set: assert property (p_irq_set) else $error("no irq");
	a_irq_gate: assert property (p_irq_gate) else $error("irq");
	a_sys_pulse: assert property (p_sys_pulse) else $error("width");
	a_sys_delay: assert property (p_sys_delay) else $error("delay");
	a_boot: assert property (p_boot) else $error("boot change");
	a_addr: assert property (p_addr) else $error("address");
	c_clear: cover property (counter_clear_out);
	c_sys: cover property (sys_reset_out);
	c_irq: cover property (wd_irq_out);
endmodule : wdcs_top_assertions
bind wdcs_top wdcs_top_assertions #(
	.RESET_DELAY_CLKS(RESET_DELAY_CLKS)
) wdcs_top_assertions_inst (
	.clock_in(clock_in), .rst_n_in(rst_n_in),
	.ext_reset_in(ext_reset_in), .isp_reset_in(isp_reset_in),
	.sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
	.sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
	.sfr_rdata_out(sfr_rdata_out), .timeout_in(timeout_in),
	.timeout_irq_enable_in(timeout_irq_enable_in),
	.timed_access_unlock_in(timed_access_unlock_in),
	.counter_clear_out(counter_clear_out), .wd_irq_out(wd_irq_out),
	.sys_reset_out(sys_reset_out),
	.boot_from_loader_out(boot_from_loader_out),
	.restart_addr_out(restart_addr_out)
);

// ===== verification/wdcs_top_test.sv
// Self-checking bench for the watchdog control and status block.
`timescale 1ns/1ps
`include "wdcs_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module wdcs_top_test;
	import wdcs_pkg::*;
	localparam int DLY = 8;
	logic       clock_in, rst_n_in, ext_reset_in, isp_reset_in, en, ul;
	logic       sfr_wr_in, sfr_rd_in, timeout_in, timed_access_unlock_in;
	logic       timeout_irq_enable_in, counter_clear_out, wd_irq_out;
	logic       sys_reset_out;
	logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, ctl, d, m, v;
	logic [15:0] restart_addr_out;
	wdcs_area_t boot_from_loader_out;
	int         checks, bad_count, n;
	wdcs_top #(.RESET_DELAY_CLKS(DLY)) wdcs_top_inst (
		.clock_in(clock_in), .rst_n_in(rst_n_in),
		.ext_reset_in(ext_reset_in), .isp_reset_in(isp_reset_in),
		.sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
		.sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
		.sfr_rdata_out(sfr_rdata_out), .timeout_in(timeout_in),
		.timeout_irq_enable_in(timeout_irq_enable_in),
		.timed_access_unlock_in(timed_access_unlock_in),
		.counter_clear_out(counter_clear_out), .wd_irq_out(wd_irq_out),
		.sys_reset_out(sys_reset_out),
		.boot_from_loader_out(boot_from_loader_out),
		.restart_addr_out(restart_addr_out));
	wdcs_cpu_model wdcs_cpu_model_inst (
		.clock_in(clock_in), .sfr_addr_out(sfr_addr_in),
		.sfr_wr_out(sfr_wr_in), .sfr_rd_out(sfr_rd_in),
		.sfr_wdata_out(sfr_wdata_in), .unlock_out(timed_access_unlock_in),
		.sfr_rdata_in(sfr_rdata_out));
	task automatic w(input logic [7:0] a, dd, input logic u);
		wdcs_cpu_model_inst.write_reg(a, dd, u);
	endtask : w
	task automatic chk_rd(input logic [7:0] a, e);
		wdcs_cpu_model_inst.read_reg(a, v);
		`CHK(v, e)
	endtask : chk_rd
	task automatic pulse(input int k);
		@(posedge clock_in);
		#1;
		timeout_in = (k == 0);
		ext_reset_in = (k == 1);
		isp_reset_in = (k == 2);
		@(posedge clock_in);
		#1;
		{timeout_in, ext_reset_in, isp_reset_in} = 3'b000;
	endtask : pulse
	// A bound of 40 cycles stands well past the shortened reset delay.
	task automatic wait_rst();
		n = 0;
		while (n < 40 && sys_reset_out !== 1'b1) begin
			@(posedge clock_in);
			#1;
			n++;
		end
	endtask : wait_rst
	task automatic print_verdict();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end
	initial begin
		void'($urandom(83));
		{rst_n_in, ext_reset_in, isp_reset_in, timeout_in} = 4'h0;
		timeout_irq_enable_in = 1'b0;
		{checks, bad_count} = 0;
		ctl = 8'h40;
		repeat (6) @(posedge clock_in);
		#1 rst_n_in = 1'b1;
		chk_rd(`WDCS_ADDR_CTRL, ctl);
		chk_rd(`WDCS_ADDR_BOOT_SEL, 8'h00);
		`CHK(restart_addr_out, 16'h0000)
		w(`WDCS_ADDR_BOOT_SEL, 8'h01, 1'b0);
		chk_rd(`WDCS_ADDR_BOOT_SEL, 8'h00);
		w(`WDCS_ADDR_BOOT_SEL, 8'hFF, 1'b1);
		chk_rd(`WDCS_ADDR_BOOT_SEL, 8'h01);
		w(8'hD9, 8'hFF, 1'b1);
		chk_rd(8'hD9, 8'h00);
		for (int i = 0; i < 16; i++) begin
			d = 8'($urandom()) & 8'hFE;
			{en, ul} = 2'($urandom());
			timeout_irq_enable_in = en;
			w(`WDCS_ADDR_CTRL, d, ul);
			m = ul ? 8'h4E : 8'h04;
			ctl = (ctl & ~m) | (d & m);
			chk_rd(`WDCS_ADDR_CTRL, ctl);
			`CHK(wd_irq_out, ctl[3] & en)
		end
		w(`WDCS_ADDR_CTRL, ctl | 8'h01, 1'b0);
		`CHK(counter_clear_out, 1'b0)
		w(`WDCS_ADDR_CTRL, ctl | 8'h01, 1'b1);
		`CHK(counter_clear_out, 1'b1)
		@(posedge clock_in);
		#1 `CHK(counter_clear_out, 1'b0)
		timeout_irq_enable_in = 1'b1;
		w(`WDCS_ADDR_CTRL, 8'h42, 1'b1);
		pulse(0);
		wait_rst();
		`CHK(n, DLY)
		if (n == 40) print_verdict();
		chk_rd(`WDCS_ADDR_CTRL, 8'h4C);
		`CHK(boot_from_loader_out, WDCS_AREA_LOADER)
		`CHK(wd_irq_out, 1'b1)
		pulse(0);
		wait_rst();
		`CHK(n, 40)
		w(`WDCS_ADDR_CTRL, 8'h42, 1'b1);
		pulse(0);
		pulse(1);
		wait_rst();
		`CHK(n, 40)
		`CHK(boot_from_loader_out, WDCS_AREA_APP)
		chk_rd(`WDCS_ADDR_CTRL, 8'h40);
		chk_rd(`WDCS_ADDR_BOOT_SEL, 8'h01);
		w(`WDCS_ADDR_CTRL, 8'h0A, 1'b1);
		pulse(2);
		chk_rd(`WDCS_ADDR_CTRL, 8'h08);
		w(`WDCS_ADDR_CTRL, 8'h04, 1'b0);
		rst_n_in = 1'b0;
		repeat (2) @(posedge clock_in);
		#1 rst_n_in = 1'b1;
		chk_rd(`WDCS_ADDR_CTRL, 8'h40);
		chk_rd(`WDCS_ADDR_BOOT_SEL, 8'h00);
		print_verdict();
	end
endmodule : wdcs_top_test
